// file: rtl/ssp_top.sv
// Pin logic of the standard and the buffered synchronous serial port.
// Assumes all pin inputs are synchronous to clk; pads resolve enables.
`timescale 1ns/1ps
module ssp_top
  import ssp_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  input  wire logic                 off_n,
  input  wire ssp_std_cfg_t         std_cfg,
  input  wire ssp_buf_cfg_t         buf_cfg,
  input  wire logic                 rx_bit_clock,
  input  wire logic                 tx_bit_clock_in,
  output ssp_drive_t                tx_bit_clock,
  input  wire logic                 serial_in_pin,
  output ssp_drive_t                serial_out_pin,
  input  wire logic                 rx_frame_sync_in,
  output ssp_drive_t                rx_frame_sync,
  input  wire logic                 tx_frame_sync_in,
  output ssp_drive_t                tx_frame_sync,
  input  wire logic                 buffered_rx_bit_clock,
  input  wire logic                 buffered_tx_bit_clock_in,
  output ssp_drive_t                buffered_tx_bit_clock,
  input  wire logic                 buffered_serial_in,
  output ssp_drive_t                buffered_serial_out,
  input  wire logic                 buffered_rx_frame_sync,
  input  wire logic                 buffered_tx_frame_sync_in,
  output ssp_drive_t                buffered_tx_frame_sync,
  input  wire logic                 std_tx_load,
  input  wire logic [WORD_BITS-1:0] std_tx_word,
  output logic                      std_tx_pending,
  output logic [WORD_BITS-1:0]      std_rx_word,
  output logic                      std_rx_valid,
  input  wire logic                 buf_tx_load,
  input  wire logic [WORD_BITS-1:0] buf_tx_word,
  output logic                      buf_tx_pending,
  output logic [WORD_BITS-1:0]      buf_rx_word,
  output logic                      buf_rx_valid,
  output ssp_status_t               std_status,
  output ssp_status_t               buf_status
);
  typedef struct packed {
    logic        std_rxc_prev;
    logic        std_txc_prev;
    logic        std_fsr_prev;
    logic        std_fsx_prev;
    logic        buf_rxc_prev;
    logic        buf_txc_prev;
    logic        buf_fsr_prev;
    logic        buf_fsx_prev;
    logic        std_fs_gen;
    logic        buf_fs_gen;
    ssp_drive_t  std_txc;
    ssp_drive_t  std_dout;
    ssp_drive_t  std_fsr;
    ssp_drive_t  std_fsx;
    ssp_drive_t  buf_txc;
    ssp_drive_t  buf_dout;
    ssp_drive_t  buf_fsx;
    ssp_status_t std_stat;
    ssp_status_t buf_stat;
  } ssp_top_state_t;

  ssp_top_state_t s;
  ssp_top_state_t next_s;
  logic           std_div_level;
  logic           buf_div_level;
  logic           std_txc_lvl;
  logic           buf_txc_lvl;
  logic           std_fsx_lvl;
  logic           std_fsr_lvl;
  logic           buf_fsr_act;
  logic           buf_fsx_act;
  logic           std_rx_edge;
  logic           std_tx_edge;
  logic           buf_rx_edge;
  logic           buf_tx_edge;
  logic           std_rx_start;
  logic           std_tx_start;
  logic           buf_rx_start;
  logic           buf_tx_start;
  logic           std_rx_busy;
  logic           std_tx_busy;
  logic           std_tx_driving;
  logic           std_tx_bit;
  logic           buf_rx_busy;
  logic           buf_tx_busy;
  logic           buf_tx_driving;
  logic           buf_tx_bit;

  ssp_clkdiv u_std_div (
    .clk      (clk),
    .arst_n   (arst_n),
    .run      (std_cfg.internal_clock_select),
    .divider  (STD_DIV_VALUE),
    .polarity (1'b0),
    .level    (std_div_level)
  );

  ssp_clkdiv u_buf_div (
    .clk      (clk),
    .arst_n   (arst_n),
    .run      (buf_cfg.internal_clock_select),
    .divider  (buf_cfg.clock_divider_value),
    .polarity (buf_cfg.clock_edge_polarity),
    .level    (buf_div_level)
  );

  // Effective levels follow the own driver when the device sources the pin, except receive sync: in multiplex mode it follows transmit sync.
  always_comb
  begin
    std_txc_lvl = std_cfg.internal_clock_select ? s.std_txc.level : tx_bit_clock_in;
    buf_txc_lvl = buf_cfg.internal_clock_select ? s.buf_txc.level : buffered_tx_bit_clock_in;
    std_fsx_lvl = std_cfg.tx_sync_output_mode ? s.std_fsx.level : tx_frame_sync_in;
    std_fsr_lvl = std_cfg.tdm_mode ? std_fsx_lvl : rx_frame_sync_in;
    buf_fsr_act = buffered_rx_frame_sync ^ buf_cfg.frame_sync_polarity;
    buf_fsx_act = (buf_cfg.tx_sync_output_mode ? s.buf_fsx.level
                   : buffered_tx_frame_sync_in) ^ buf_cfg.frame_sync_polarity;
    std_rx_edge = s.std_rxc_prev & ~rx_bit_clock;
    std_tx_edge = ~s.std_txc_prev & std_txc_lvl;
    buf_rx_edge = buf_cfg.clock_edge_polarity ? (~s.buf_rxc_prev & buffered_rx_bit_clock)
                  : (s.buf_rxc_prev & ~buffered_rx_bit_clock);
    buf_tx_edge = buf_cfg.clock_edge_polarity ? (s.buf_txc_prev & ~buf_txc_lvl)
                  : (~s.buf_txc_prev & buf_txc_lvl);
    std_rx_start = s.std_fsr_prev & ~std_fsr_lvl;
    std_tx_start = s.std_fsx_prev & ~std_fsx_lvl;
    buf_rx_start = ~s.buf_fsr_prev & buf_fsr_act;
    buf_tx_start = ~s.buf_fsx_prev & buf_fsx_act;
  end

  ssp_shifter u_std_shift (
    .clk        (clk),
    .arst_n     (arst_n),
    .rx_edge    (std_rx_edge),
    .rx_start   (std_rx_start),
    .serial_in  (serial_in_pin),
    .tx_edge    (std_tx_edge),
    .tx_start   (std_tx_start),
    .tx_load    (std_tx_load),
    .tx_word    (std_tx_word),
    .rx_word    (std_rx_word),
    .rx_done    (std_rx_valid),
    .rx_busy    (std_rx_busy),
    .tx_pending (std_tx_pending),
    .tx_busy    (std_tx_busy),
    .tx_driving (std_tx_driving),
    .tx_bit     (std_tx_bit)
  );

  ssp_shifter u_buf_shift (
    .clk        (clk),
    .arst_n     (arst_n),
    .rx_edge    (buf_rx_edge),
    .rx_start   (buf_rx_start),
    .serial_in  (buffered_serial_in),
    .tx_edge    (buf_tx_edge),
    .tx_start   (buf_tx_start),
    .tx_load    (buf_tx_load),
    .tx_word    (buf_tx_word),
    .rx_word    (buf_rx_word),
    .rx_done    (buf_rx_valid),
    .rx_busy    (buf_rx_busy),
    .tx_pending (buf_tx_pending),
    .tx_busy    (buf_tx_busy),
    .tx_driving (buf_tx_driving),
    .tx_bit     (buf_tx_bit)
  );

  always_comb
  begin
    next_s = s;
    next_s.std_rxc_prev = rx_bit_clock;
    next_s.std_txc_prev = std_txc_lvl;
    next_s.std_fsr_prev = std_fsr_lvl;
    next_s.std_fsx_prev = std_fsx_lvl;
    next_s.buf_rxc_prev = buffered_rx_bit_clock;
    next_s.buf_txc_prev = buf_txc_lvl;
    next_s.buf_fsr_prev = buf_fsr_act;
    next_s.buf_fsx_prev = buf_fsx_act;
    next_s.std_txc.level = std_div_level;
    next_s.std_txc.enable = off_n & std_cfg.internal_clock_select;
    next_s.buf_txc.level = buf_div_level;
    next_s.buf_txc.enable = off_n & buf_cfg.internal_clock_select;
    next_s.std_dout.level = std_tx_bit;
    next_s.std_dout.enable = off_n & std_tx_driving;
    next_s.buf_dout.level = buf_tx_bit;
    next_s.buf_dout.enable = off_n & buf_tx_driving;
    next_s.std_fsr.level = std_cfg.tdm_address;
    next_s.std_fsr.enable = off_n & std_cfg.tdm_mode & std_cfg.tx_sync_output_mode;
    // A generated sync lasts one bit period, then the word follows it.
    next_s.std_fsx.enable = off_n & std_cfg.tx_sync_output_mode;
    if (!std_cfg.tx_sync_output_mode)
    begin
      next_s.std_fs_gen = 1'b0;
      next_s.std_fsx.level = 1'b1;
    end
    else if (std_tx_edge)
    begin
      next_s.std_fs_gen = ~s.std_fs_gen & std_tx_pending & ~std_tx_busy;
      next_s.std_fsx.level = ~next_s.std_fs_gen;
    end
    next_s.buf_fsx.enable = off_n & buf_cfg.tx_sync_output_mode;
    if (!buf_cfg.tx_sync_output_mode)
      next_s.buf_fs_gen = 1'b0;
    else if (buf_tx_edge)
      next_s.buf_fs_gen = ~s.buf_fs_gen & buf_tx_pending & ~buf_tx_busy;
    next_s.buf_fsx.level = next_s.buf_fs_gen ^ buf_cfg.frame_sync_polarity;
    next_s.std_stat.rx_clock_pin_level = rx_bit_clock;
    next_s.std_stat.tx_clock_pin_level = std_txc_lvl;
    next_s.buf_stat.rx_clock_pin_level = buffered_rx_bit_clock;
    next_s.buf_stat.tx_clock_pin_level = buf_txc_lvl;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s <= '0;
      s.std_fsx.level <= 1'b1;
      // A buffered sync already asserted at release must not count as a start.
      s.buf_fsr_prev <= 1'b1;
      s.buf_fsx_prev <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign tx_bit_clock           = s.std_txc;
  assign serial_out_pin         = s.std_dout;
  assign rx_frame_sync          = s.std_fsr;
  assign tx_frame_sync          = s.std_fsx;
  assign buffered_tx_bit_clock  = s.buf_txc;
  assign buffered_serial_out    = s.buf_dout;
  assign buffered_tx_frame_sync = s.buf_fsx;
  assign std_status             = s.std_stat;
  assign buf_status             = s.buf_stat;

  property p_buf_clk_input;
    @(posedge clk) disable iff (!arst_n)
      !buf_cfg.internal_clock_select |=> !buffered_tx_bit_clock.enable;
  endproperty
  a_buf_clk_input: assert property (p_buf_clk_input)
    else $error("buffered transmit clock driven while external");

  property p_off_floats;
    @(posedge clk) disable iff (!arst_n)
      !off_n |=> !(tx_bit_clock.enable || serial_out_pin.enable || tx_frame_sync.enable
                  || rx_frame_sync.enable || buffered_tx_bit_clock.enable
                  || buffered_serial_out.enable || buffered_tx_frame_sync.enable);
  endproperty
  a_off_floats: assert property (p_off_floats)
    else $error("an output driven while outputs are disabled");

  property p_std_quarter;
    @(posedge clk) disable iff (!arst_n)
      (std_cfg.internal_clock_select && $rose(tx_bit_clock.level)) ##1
      std_cfg.internal_clock_select[*3] |=> $rose(tx_bit_clock.level);
  endproperty
  a_std_quarter: assert property (p_std_quarter)
    else $error("standard internal clock period is not four cycles");

  property p_std_half;
    @(posedge clk) disable iff (!arst_n)
      (std_cfg.internal_clock_select && $rose(tx_bit_clock.level)) ##1
      std_cfg.internal_clock_select |-> tx_bit_clock.level ##1 !tx_bit_clock.level;
  endproperty
  a_std_half: assert property (p_std_half)
    else $error("standard internal clock not two high two low");

  property p_dout_float;
    @(posedge clk) disable iff (!arst_n)
      serial_out_pin.enable |-> $past(std_tx_busy) && $past(off_n);
  endproperty
  a_dout_float: assert property (p_dout_float)
    else $error("data output driven with no transmission");

  property p_std_rx_start;
    @(posedge clk) disable iff (!arst_n)
      std_rx_start && !std_rx_busy |=> std_rx_busy;
  endproperty
  a_std_rx_start: assert property (p_std_rx_start)
    else $error("receive frame sync fall did not start reception");

  property p_std_tx_start;
    @(posedge clk) disable iff (!arst_n)
      std_tx_start && std_tx_pending && !std_tx_busy |=> std_tx_busy && !std_tx_pending;
  endproperty
  a_std_tx_start: assert property (p_std_tx_start)
    else $error("transmit frame sync fall did not start transmission");

  property p_fsx_input;
    @(posedge clk) disable iff (!arst_n)
      !std_cfg.tx_sync_output_mode |=> !tx_frame_sync.enable && tx_frame_sync.level;
  endproperty
  a_fsx_input: assert property (p_fsx_input)
    else $error("standard transmit sync driven in input mode");

  property p_tdm_addr;
    @(posedge clk) disable iff (!arst_n)
      rx_frame_sync.enable |-> $past(std_cfg.tdm_mode)
                               && rx_frame_sync.level == $past(std_cfg.tdm_address);
  endproperty
  a_tdm_addr: assert property (p_tdm_addr)
    else $error("receive sync pin driven outside multiplex mode");

  property p_buf_rx_pol;
    @(posedge clk) disable iff (!arst_n)
      $rose(buffered_rx_frame_sync != buf_cfg.frame_sync_polarity) && !buf_rx_busy
      |=> buf_rx_busy;
  endproperty
  a_buf_rx_pol: assert property (p_buf_rx_pol)
    else $error("buffered receive start at wrong sync polarity");
endmodule

// file: rtl/ssp_pkg.sv
// Shared constants and carrier types of the serial port pin logic.
// Assumes a single machine clock that also samples every pin.
package ssp_pkg;
  localparam int          WORD_BITS     = 16;
  localparam int          DIV_W         = 8;
  localparam logic [4:0]  BIT_COUNT     = 5'h10;
  localparam logic [4:0]  LAST_BIT      = 5'h0F;
  localparam logic [7:0]  STD_DIV_VALUE = 8'h03;
  localparam logic [15:0] WORD_RESET    = 16'h0000;
  localparam logic [4:0]  CNT_RESET     = 5'h00;
  localparam logic [7:0]  DIV_RESET     = 8'h00;

  // One two-way pin as driven by the device.
  typedef struct packed {
    logic level;
    logic enable;
  } ssp_drive_t;

  typedef struct packed {
    logic       internal_clock_select;
    logic       tx_sync_output_mode;
    logic       tdm_mode;
    logic       tdm_address;
  } ssp_std_cfg_t;

  typedef struct packed {
    logic             internal_clock_select;
    logic             tx_sync_output_mode;
    logic             clock_edge_polarity;
    logic             frame_sync_polarity;
    logic [DIV_W-1:0] clock_divider_value;
  } ssp_buf_cfg_t;

  typedef struct packed {
    logic rx_clock_pin_level;
    logic tx_clock_pin_level;
  } ssp_status_t;
endpackage

// file: rtl/ssp_clkdiv.sv
// Internal bit clock generator: period of divider+1 machine clocks, or 2 for divider 0.
// Assumes software keeps the divider steady while the clock is used.
`timescale 1ns/1ps
module ssp_clkdiv
  import ssp_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             run,
  input  wire logic [DIV_W-1:0] divider,
  input  wire logic             polarity,
  output logic                  level
);
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             level;
  } ssp_div_state_t;

  ssp_div_state_t   s;
  ssp_div_state_t   next_s;
  logic [DIV_W-1:0] half;
  logic [DIV_W-1:0] high_len;

  always_comb
  begin
    next_s = s;
    half = divider >> 1;
    if (divider[0])
      high_len = half + 8'h01;
    else if (polarity)
      high_len = half;
    else
      high_len = half + 8'h01;
    if (!run)
    begin
      // Parking the count at its end makes the first high phase a full one.
      next_s.cnt = divider;
      next_s.level = 1'b0;
    end
    else if (divider == DIV_RESET)
    begin
      // Divide-by-one cannot leave a flip-flop; the fastest is half rate.
      next_s.level = ~s.level;
    end
    else
    begin
      next_s.cnt = (s.cnt >= divider) ? DIV_RESET : s.cnt + 8'h01;
      next_s.level = (next_s.cnt < high_len);
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign level = s.level;
endmodule

// file: rtl/ssp_shifter.sv
// Receive and transmit shift registers of one serial port.
// Assumes edge and start strobes are one-cycle pulses from the pin logic.
`timescale 1ns/1ps
module ssp_shifter
  import ssp_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  input  wire logic                 rx_edge,
  input  wire logic                 rx_start,
  input  wire logic                 serial_in,
  input  wire logic                 tx_edge,
  input  wire logic                 tx_start,
  input  wire logic                 tx_load,
  input  wire logic [WORD_BITS-1:0] tx_word,
  output logic [WORD_BITS-1:0]      rx_word,
  output logic                      rx_done,
  output logic                      rx_busy,
  output logic                      tx_pending,
  output logic                      tx_busy,
  output logic                      tx_driving,
  output logic                      tx_bit
);
  typedef struct packed {
    logic [WORD_BITS-1:0] rx_sr;
    logic [WORD_BITS-1:0] rx_word;
    logic [WORD_BITS-1:0] tx_sr;
    logic [WORD_BITS-1:0] tx_buf;
    logic [4:0]           rx_cnt;
    logic [4:0]           tx_cnt;
    logic                 rx_busy;
    logic                 rx_done;
    logic                 tx_busy;
    logic                 tx_pending;
    logic                 tx_bit;
  } ssp_shift_state_t;

  ssp_shift_state_t s;
  ssp_shift_state_t next_s;

  always_comb
  begin
    next_s = s;
    next_s.rx_done = 1'b0;
    if (rx_start && !s.rx_busy)
    begin
      next_s.rx_busy = 1'b1;
      next_s.rx_cnt = CNT_RESET;
    end
    else if (s.rx_busy && rx_edge)
    begin
      next_s.rx_sr = {s.rx_sr[WORD_BITS-2:0], serial_in};
      next_s.rx_cnt = s.rx_cnt + 5'h01;
      if (s.rx_cnt == LAST_BIT)
      begin
        next_s.rx_busy = 1'b0;
        next_s.rx_word = next_s.rx_sr;
        next_s.rx_done = 1'b1;
      end
    end
    if (tx_load && !s.tx_pending)
    begin
      next_s.tx_pending = 1'b1;
      next_s.tx_buf = tx_word;
    end
    if (tx_start && s.tx_pending && !s.tx_busy)
    begin
      next_s.tx_busy = 1'b1;
      next_s.tx_pending = 1'b0;
      next_s.tx_sr = s.tx_buf;
      next_s.tx_cnt = CNT_RESET;
    end
    else if (s.tx_busy && tx_edge)
    begin
      if (s.tx_cnt == BIT_COUNT)
        next_s.tx_busy = 1'b0;
      else
      begin
        next_s.tx_bit = s.tx_sr[WORD_BITS-1];
        next_s.tx_sr = {s.tx_sr[WORD_BITS-2:0], 1'b0};
        next_s.tx_cnt = s.tx_cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign rx_word    = s.rx_word;
  assign rx_done    = s.rx_done;
  assign rx_busy    = s.rx_busy;
  assign tx_pending = s.tx_pending;
  assign tx_busy    = s.tx_busy;
  assign tx_driving = s.tx_busy && (s.tx_cnt != CNT_RESET);
  assign tx_bit     = s.tx_bit;
endmodule

// file: verification/ssp_far_end.sv
// Behavioural far end of one serial port: bit clock, frame sync, data.
// Assumes the machine clock; the bit clock stands high outside frames.
`timescale 1ns/1ps
module ssp_far_end
(
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [15:0] word,
  output logic             bit_clk,
  output logic             sync,
  output logic             data,
  output logic             busy
);
  logic start;

  initial
  begin
    bit_clk = 1'b1;
    sync    = 1'b1;
    data    = 1'b0;
    busy    = 1'b0;
    forever
    begin
      @(posedge clk);
      start = go;
      @(negedge clk);
      if (start)
      begin
        busy = 1'b1;
        sync = 1'b0;
        data = word[15];
        repeat (4) @(negedge clk);
        for (int i = 1; i <= 17; i++)
        begin
          bit_clk = 1'b0;
          repeat (4) @(negedge clk);
          bit_clk = 1'b1;
          sync    = 1'b1;
          data    = (i < 16) ? word[15-i] : ~data;
          repeat (4) @(negedge clk);
        end
        busy = 1'b0;
      end
      else
        data = ~data;
    end
  end
endmodule

// file: verification/test_sync_serial_port_pins.sv
// Self-checking bench of the serial port pin logic.
// Assumes one far end per port and pins resolved from the device enables.
`timescale 1ns/1ps
module test_sync_serial_port_pins
  import ssp_pkg::*;
;
  logic clk = 1'b0, arst_n = 1'b0, off_n = 1'b1;
  ssp_std_cfg_t std_cfg = '0;
  ssp_buf_cfg_t buf_cfg = '0;
  logic std_tx_load = 1'b0, buf_tx_load = 1'b0, s_go = 1'b0, b_go = 1'b0;
  logic [15:0] std_tx_word = '0, buf_tx_word = '0, s_far = '0, b_far = '0;
  logic [15:0] s_cap, b_cap, std_rx_word, buf_rx_word;
  logic std_tx_pending, std_rx_valid, buf_tx_pending, buf_rx_valid;
  ssp_drive_t tx_bit_clock, serial_out_pin, rx_frame_sync, tx_frame_sync;
  ssp_drive_t buffered_tx_bit_clock, buffered_serial_out, buffered_tx_frame_sync;
  ssp_status_t std_status, buf_status;
  wire s_clk, s_sync, s_data, s_busy, b_clk, b_sync, b_data, b_busy;
  int mismatches = 0, cmp_count = 0, cycles = 0, valid_cnt = 0;
  wire [6:0] ens = {tx_bit_clock.enable, serial_out_pin.enable, rx_frame_sync.enable,
                    tx_frame_sync.enable, buffered_tx_bit_clock.enable,
                    buffered_serial_out.enable, buffered_tx_frame_sync.enable};
  wire s_tclk  = tx_bit_clock.enable ? tx_bit_clock.level : s_clk;
  wire s_tsync = tx_frame_sync.enable ? tx_frame_sync.level : s_sync;
  wire s_rsync = rx_frame_sync.enable ? rx_frame_sync.level : s_sync;
  wire b_tclk  = buffered_tx_bit_clock.enable ? buffered_tx_bit_clock.level : b_clk;
  wire b_tsync = buffered_tx_frame_sync.enable ? buffered_tx_frame_sync.level : b_sync;

  always #5 clk = ~clk;

  ssp_top ssp_top_i (.clk, .arst_n, .off_n, .std_cfg, .buf_cfg, .rx_bit_clock(s_clk),
    .tx_bit_clock_in(s_tclk), .tx_bit_clock, .serial_in_pin(s_data), .serial_out_pin,
    .rx_frame_sync_in(s_rsync), .rx_frame_sync, .tx_frame_sync_in(s_tsync), .tx_frame_sync,
    .buffered_rx_bit_clock(b_clk), .buffered_tx_bit_clock_in(b_tclk), .buffered_tx_bit_clock,
    .buffered_serial_in(b_data), .buffered_serial_out, .buffered_rx_frame_sync(b_sync),
    .buffered_tx_frame_sync_in(b_tsync), .buffered_tx_frame_sync, .std_tx_load, .std_tx_word,
    .std_tx_pending, .std_rx_word, .std_rx_valid, .buf_tx_load, .buf_tx_word,
    .buf_tx_pending, .buf_rx_word, .buf_rx_valid, .std_status, .buf_status);
  ssp_far_end far_std (.clk(clk), .go(s_go), .word(s_far), .bit_clk(s_clk), .sync(s_sync),
    .data(s_data), .busy(s_busy));
  ssp_far_end far_buf (.clk(clk), .go(b_go), .word(b_far), .bit_clk(b_clk), .sync(b_sync),
    .data(b_data), .busy(b_busy));

  // Collect transmitted bits where the far end would take them.
  always @(negedge s_clk) if (serial_out_pin.enable === 1'b1) s_cap = {s_cap[14:0], serial_out_pin.level};
  always @(negedge b_clk) if (buffered_serial_out.enable === 1'b1) b_cap = {b_cap[14:0], buffered_serial_out.level};
  always @(negedge clk)
  begin
    valid_cnt = valid_cnt + int'(std_rx_valid === 1'b1) + int'(buf_rx_valid === 1'b1);
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      close_out();
    end
  end

  task automatic close_out;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: %s got %h", $time, what, got);
    end
  endtask

  // Count one high and one low phase of an internal bit clock.
  task automatic hilo(input bit sel, output int hi, output int lo);
    hi = 0;
    lo = 0;
    while ((sel ? buffered_tx_bit_clock.level : tx_bit_clock.level) !== 1'b0) @(negedge clk);
    while ((sel ? buffered_tx_bit_clock.level : tx_bit_clock.level) !== 1'b1) @(negedge clk);
    while ((sel ? buffered_tx_bit_clock.level : tx_bit_clock.level) === 1'b1)
    begin
      hi++;
      @(negedge clk);
    end
    while ((sel ? buffered_tx_bit_clock.level : tx_bit_clock.level) === 1'b0)
    begin
      lo++;
      @(negedge clk);
    end
  endtask

  task automatic t_clocks;
    int hi, lo, p;
    logic [7:0] dv [5] = '{8'h00, 8'h03, 8'h04, 8'h04, 8'h07};
    logic pl [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    repeat (2) @(negedge clk);
    check(16'(ens), 16'h0000, "drives after reset");
    check(16'({std_status, buf_status}), 16'h000F, "clock pin levels");
    std_cfg = '{1'b1, 1'b1, 1'b1, 1'b1};
    buf_cfg.internal_clock_select = 1'b1;
    buf_cfg.tx_sync_output_mode = 1'b1;
    repeat (2) @(negedge clk);
    check(16'(ens), 16'h005D, "output modes");
    check(16'(rx_frame_sync.level), 16'h0001, "port address");
    hilo(1'b0, hi, lo);
    check(16'({hi[7:0], lo[7:0]}), 16'h0202, "quarter rate clock");
    off_n = 1'b0;
    repeat (2) @(negedge clk);
    check(16'(ens), 16'h0000, "drives while off");
    off_n = 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      buf_cfg.clock_divider_value = dv[i];
      buf_cfg.clock_edge_polarity = pl[i];
      repeat (20) @(negedge clk);
      hilo(1'b1, hi, lo);
      p = int'(dv[i]) / 2;
      if (dv[i] == 8'h00)
        p = 1;
      else if (dv[i][0])
        p = (int'(dv[i]) + 1) / 2;
      check(16'(hi), 16'((dv[i][0] || dv[i] == 8'h00) ? p : (pl[i] ? p : p + 1)), "high");
      check(16'(lo), 16'((dv[i][0] || dv[i] == 8'h00) ? p : (pl[i] ? p + 1 : p)), "low");
    end
    std_cfg = '0;
    buf_cfg = '0;
    repeat (4) @(negedge clk);
  endtask

  task automatic t_frame(input bit b, input logic [15:0] tw, input logic [15:0] rw);
    if (b)
      {buf_tx_word, buf_tx_load, b_far} = {tw, 1'b1, rw};
    else
      {std_tx_word, std_tx_load, s_far} = {tw, 1'b1, rw};
    @(negedge clk);
    {buf_tx_load, std_tx_load} = 2'b00;
    @(negedge clk);
    check(16'(b ? buf_tx_pending : std_tx_pending), 16'h0001, "pending");
    check(16'(ens), 16'h0000, "idle data drive");
    {s_cap, b_cap, valid_cnt} = '0;
    {b_go, s_go} = {b, !b};
    repeat (2) @(negedge clk);
    {b_go, s_go} = 2'b00;
    while ((b ? b_busy : s_busy) === 1'b1) @(posedge clk);
    repeat (4) @(negedge clk);
    check(b ? b_cap : s_cap, tw, "sent word");
    check(b ? buf_rx_word : std_rx_word, rw, "received word");
    check(16'(valid_cnt), 16'h0001, "receive pulses");
    check(16'(ens), 16'h0000, "data drive after frame");
  endtask

  initial
  begin
    repeat (6) @(negedge clk);
    check(16'({ens, tx_frame_sync.level}), 16'h0001, "drives in reset");
    arst_n = 1'b1;
    t_clocks();
    t_frame(1'b0, 16'hA5C3, 16'h3C96);
    buf_cfg.frame_sync_polarity = 1'b1;
    t_frame(1'b1, 16'h8001, 16'h7FFE);
    close_out();
  end
endmodule
